// [hw/rdr_i2c_slave.sv]
// Serial management slave with byte pointer and auto increment
`timescale 1ns/10ps
module rdr_i2c_slave (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic scl,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    rdr_rbus_if.ctrl rbus
);
    import rdr_pkg::*;
    rdr_i2c_state_t state_r, state_nxt;
    rdr_phase_t phase_r, phase_nxt;
    logic scl_q_r, sda_q_r;
    logic [7:0] shift_r, shift_nxt;
    logic [3:0] cnt_r, cnt_nxt;
    logic [7:0] ptr_r, ptr_nxt;
    logic rw_r, rw_nxt;
    logic oe_r, oe_nxt;
    logic wr_r, wr_nxt;
    logic scl_rise, scl_fall, start_c, stop_c, addr_hit;
    assign scl_rise = scl & ~scl_q_r;
    assign scl_fall = ~scl & scl_q_r;
    assign start_c = scl & scl_q_r & sda_q_r & ~sda_in;
    assign stop_c = scl & scl_q_r & ~sda_q_r & sda_in;
    assign addr_hit = (shift_r[7:1] == I2C_DEV_ADDR);
    always_comb begin
        state_nxt = state_r;
        phase_nxt = phase_r;
        shift_nxt = shift_r;
        cnt_nxt = cnt_r;
        ptr_nxt = ptr_r;
        rw_nxt = rw_r;
        oe_nxt = oe_r;
        wr_nxt = 1'b0;
        if (start_c) begin
            state_nxt = I2C_RECV;
            phase_nxt = PH_ADDR;
            cnt_nxt = 4'h0;
            oe_nxt = 1'b0;
        end else if (stop_c) begin
            state_nxt = I2C_IDLE;
            oe_nxt = 1'b0;
        end else begin
            unique case (state_r)
                I2C_IDLE: begin
                    cnt_nxt = 4'h0;
                end
                I2C_RECV: begin
                    if (scl_rise && cnt_r != BIT_CNT_BYTE) begin
                        shift_nxt = {shift_r[6:0], sda_in};
                        cnt_nxt = cnt_r + 4'h1;
                    end
                    if (scl_fall && cnt_r == BIT_CNT_BYTE) begin
                        cnt_nxt = 4'h0;
                        state_nxt = I2C_ACK;
                        oe_nxt = 1'b1;
                        unique case (phase_r)
                            PH_ADDR: begin
                                rw_nxt = shift_r[0];
                                if (!addr_hit) begin
                                    state_nxt = I2C_IDLE;
                                    oe_nxt = 1'b0;
                                end
                            end
                            PH_PTR: ptr_nxt = shift_r;
                            PH_DATA: wr_nxt = 1'b1;
                        endcase
                    end
                end
                I2C_ACK: begin
                    if (scl_fall) begin
                        oe_nxt = 1'b0;
                        if (phase_r == PH_ADDR && rw_r) begin
                            state_nxt = I2C_SEND;
                            shift_nxt = rbus.rdata;
                            oe_nxt = ~rbus.rdata[7];
                        end else begin
                            state_nxt = I2C_RECV;
                            if (phase_r == PH_DATA) begin
                                ptr_nxt = ptr_r + 8'h01;
                            end
                            phase_nxt = (phase_r == PH_ADDR) ? PH_PTR
                                : PH_DATA;
                        end
                    end
                end
                I2C_SEND: begin
                    if (scl_fall) begin
                        cnt_nxt = cnt_r + 4'h1;
                        shift_nxt = {shift_r[6:0], 1'b0};
                        oe_nxt = ~shift_r[6];
                        if (cnt_r == BIT_CNT_LAST) begin
                            state_nxt = I2C_MACK;
                            oe_nxt = 1'b0;
                            cnt_nxt = 4'h0;
                            ptr_nxt = ptr_r + 8'h01;
                        end
                    end
                end
                I2C_MACK: begin
                    if (scl_rise && sda_in) begin
                        state_nxt = I2C_IDLE;
                    end else if (scl_fall) begin
                        state_nxt = I2C_SEND;
                        shift_nxt = rbus.rdata;
                        oe_nxt = ~rbus.rdata[7];
                    end
                end
            endcase
        end
    end
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            state_r <= I2C_IDLE;
            phase_r <= PH_ADDR;
            scl_q_r <= 1'b1;
            sda_q_r <= 1'b1;
            shift_r <= 8'h00;
            cnt_r <= 4'h0;
            ptr_r <= 8'h00;
            rw_r <= 1'b0;
            oe_r <= 1'b0;
            wr_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            phase_r <= phase_nxt;
            scl_q_r <= scl;
            sda_q_r <= sda_in;
            shift_r <= shift_nxt;
            cnt_r <= cnt_nxt;
            ptr_r <= ptr_nxt;
            rw_r <= rw_nxt;
            oe_r <= oe_nxt;
            wr_r <= wr_nxt;
        end
    end
    // Open drain: only ever pulls low
    assign sda_out = 1'b0;
    assign sda_oe = oe_r;
    assign rbus.addr = ptr_r;
    assign rbus.wdata = shift_r;
    assign rbus.wr = wr_r;
endmodule

// [hw/rdr_lane_ctrl.sv]
// Redriver lane, sideband and equalization control registers
//
// Contract
// - Snoop-off bit clear means link traffic monitored
// - Route 00 follows mode and orientation selects
// - Route 01 straight, 10 crossed, 11 open
// - Nonzero route ignores mode and orientation
// - Lane-off bits act only with snoop off
// - Lane-off 0 enables lane, 1 disables
// - Nonzero host restore resets all registers; with takeover low the eq fields keep the strap code
// - Nonzero link restore resets link config set
// - Pair-2 transmit equalization code, reset zero
// - Pair-2 receive equalization code, reset zero
// - Takeover low: fields follow straps, writes ignored
// - Takeover high: written codes drive the pins
// - Snoop on: lanes follow snooped lane count
// - Snoop on: lanes follow snooped power state
`timescale 1ns/10ps
module rdr_lane_ctrl (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic scl,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic eq_software_takeover,
    input wire logic [1:0] downstream_eq_straps,
    input wire logic mode_select_high,
    input wire logic orientation_select,
    input wire logic snoop_lc_wr,
    input wire logic snoop_ps_wr,
    input wire logic [7:0] snoop_data,
    output logic aux_snoop_en,
    output logic sbu_straight,
    output logic sbu_crossed,
    output logic [3:0] display_lane_en,
    output logic [3:0] dfp_tx_pair2_eq_code,
    output logic [3:0] dfp_rx_pair2_eq_code,
    output logic [3:0] dfp_tx_pair1_eq_code,
    output logic [3:0] dfp_rx_pair1_eq_code
);
    import rdr_pkg::*;

    rdr_rbus_if rbus ();

    rdr_i2c_slave u_i2c (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .scl(scl),
        .sda_in(sda_in),
        .sda_out(sda_out),
        .sda_oe(sda_oe),
        .rbus(rbus.ctrl)
    );

    logic [7:0] ctrl_r, ctrl_nxt;
    logic [7:0] rst_fld_r, rst_fld_nxt;
    logic [7:0] eq2_r, eq2_nxt;
    logic [7:0] eq1_r, eq1_nxt;
    logic [4:0] lcount_r, lcount_nxt;
    logic [1:0] pstate_r, pstate_nxt;
    logic [3:0] strap_code_r;
    logic strap_done_r;
    logic msh_q_r;
    logic snoop_en_r;
    logic straight_r, straight_nxt;
    logic crossed_r, crossed_nxt;

    logic wr_ctrl, wr_rst, wr_eq2, wr_eq1;
    logic host_rst, link_rst, msh_fall, link_clr;
    logic snoop_off_w;
    logic [3:0] lane_off_w;
    logic display_lane0_off, display_lane1_off;
    logic display_lane2_off, display_lane3_off;
    logic [3:0] strap_eq_w;
    logic [7:0] strap_pair_w;
    logic [1:0] sideband_route_force;
    rdr_route_t route_w;
    logic pins_conn_w;

    // Register decode
    assign wr_ctrl = rbus.wr && (rbus.addr == ADDR_CTRL);
    assign wr_rst = rbus.wr && (rbus.addr == ADDR_RST);
    assign wr_eq2 = rbus.wr && (rbus.addr == ADDR_EQ2);
    assign wr_eq1 = rbus.wr && (rbus.addr == ADDR_EQ1);

    // Restore strobes come from the one-cycle field copy
    assign host_rst = |rst_fld_r[HOST_RST_LSB +: 4];
    assign link_rst = |rst_fld_r[LINK_RST_LSB +: 4];
    assign msh_fall = msh_q_r & ~mode_select_high;
    assign link_clr = host_rst | link_rst | msh_fall;

    // Control fields
    assign snoop_off_w = ctrl_r[SNOOP_OFF_BIT];
    assign display_lane0_off = ctrl_r[LANE_LSB];
    assign display_lane1_off = ctrl_r[LANE_LSB + 1];
    assign display_lane2_off = ctrl_r[LANE_LSB + 2];
    assign display_lane3_off = ctrl_r[LANE_LSB + 3];
    assign lane_off_w = {display_lane3_off, display_lane2_off,
        display_lane1_off, display_lane0_off};
    assign sideband_route_force = ctrl_r[ROUTE_LSB +: 2];
    assign route_w = rdr_route_t'(sideband_route_force);

    // Strap lookup, both fields of a pair share one code
    assign strap_eq_w = STRAP_EQ_MAP[{downstream_eq_straps, 2'b00} +: 4];
    assign strap_pair_w = {strap_code_r, strap_code_r};

    // Write side
    assign ctrl_nxt = host_rst ? CTRL_RST
        : wr_ctrl ? (rbus.wdata & CTRL_MASK) : ctrl_r;
    // Field holds the written value for one cycle only
    assign rst_fld_nxt = wr_rst ? rbus.wdata : RST_FLD_RST;
    // Straps own the fields until software takes over
    assign eq2_nxt = !eq_software_takeover ? strap_pair_w
        : host_rst ? EQ_RST
        : wr_eq2 ? rbus.wdata : eq2_r;
    assign eq1_nxt = !eq_software_takeover ? strap_pair_w
        : host_rst ? EQ_RST
        : wr_eq1 ? rbus.wdata : eq1_r;

    // A snoop write in the clear cycle wins so it is not lost
    assign lcount_nxt = snoop_lc_wr ? snoop_data[4:0]
        : link_clr ? LCOUNT_RST : lcount_r;
    assign pstate_nxt = snoop_ps_wr ? snoop_data[1:0]
        : link_clr ? PSTATE_RST : pstate_r;

    // Sideband routing
    assign pins_conn_w = (route_w == ROUTE_PINS) && mode_select_high;
    assign straight_nxt = (route_w == ROUTE_STRAIGHT)
        || (pins_conn_w && !orientation_select);
    assign crossed_nxt = (route_w == ROUTE_CROSS)
        || (pins_conn_w && orientation_select);

    // Read side, unmapped offsets read zero
    assign rbus.rdata = (rbus.addr == ADDR_CTRL) ? ctrl_r
        : (rbus.addr == ADDR_RST) ? rst_fld_r
        : (rbus.addr == ADDR_EQ2) ? eq2_r
        : (rbus.addr == ADDR_EQ1) ? eq1_r : RDATA_NONE;

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            ctrl_r <= CTRL_RST;
            rst_fld_r <= RST_FLD_RST;
            eq2_r <= EQ_RST;
            eq1_r <= EQ_RST;
            lcount_r <= LCOUNT_RST;
            pstate_r <= PSTATE_RST;
        end else begin
            ctrl_r <= ctrl_nxt;
            rst_fld_r <= rst_fld_nxt;
            eq2_r <= eq2_nxt;
            eq1_r <= eq1_nxt;
            lcount_r <= lcount_nxt;
            pstate_r <= pstate_nxt;
        end
    end

    // Straps caught once, on the first edge after release
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            strap_done_r <= 1'b0;
            strap_code_r <= 4'h0;
        end else if (!strap_done_r) begin
            strap_done_r <= 1'b1;
            strap_code_r <= strap_eq_w;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            msh_q_r <= 1'b0;
            snoop_en_r <= 1'b1;
            straight_r <= 1'b0;
            crossed_r <= 1'b0;
        end else begin
            msh_q_r <= mode_select_high;
            snoop_en_r <= ~snoop_off_w;
            straight_r <= straight_nxt;
            crossed_r <= crossed_nxt;
        end
    end

    // One gate per display lane
    for (genvar i = 0; i < 4; i++) begin : g_lane
        rdr_lane_gate #(
            .LANE(i)
        ) u_gate (
            .clk_sys(clk_sys),
            .resetn(resetn),
            .snoop_off(snoop_off_w),
            .lane_off(lane_off_w[i]),
            .lane_count(lcount_r),
            .power_state(pstate_r),
            .lane_en(display_lane_en[i])
        );
    end

    assign aux_snoop_en = snoop_en_r;
    assign sbu_straight = straight_r;
    assign sbu_crossed = crossed_r;
    assign dfp_tx_pair2_eq_code = eq2_r[TX_LSB +: 4];
    assign dfp_rx_pair2_eq_code = eq2_r[RX_LSB +: 4];
    assign dfp_tx_pair1_eq_code = eq1_r[TX_LSB +: 4];
    assign dfp_rx_pair1_eq_code = eq1_r[RX_LSB +: 4];

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!resetn);

    // Snoop output tracks the control bit
    snoop_flag_a: assert property (
        wr_ctrl && !host_rst ##1 1'b1 |=>
            aux_snoop_en == !$past(rbus.wdata[SNOOP_OFF_BIT], 2))
        else $error("snoop enable does not follow control bit");

    // Lane gates are registered, one edge behind the control bits
    manual_lane_a: assert property (
        snoop_off_w && display_lane0_off |=> !display_lane_en[0])
        else $error("manual lane off not applied");

    snoop_lanes_a: assert property (
        !snoop_off_w && lcount_r == 5'h02 && pstate_r != PSTATE_DOWN
            |=> display_lane_en == 4'h3)
        else $error("snooped lane count not applied");

    power_down_a: assert property (
        !snoop_off_w && pstate_r == PSTATE_DOWN
            |=> display_lane_en == 4'h0)
        else $error("snooped power down not applied");

    route_force_a: assert property (
        route_w == ROUTE_CROSS |=> sbu_crossed && !sbu_straight)
        else $error("forced crossed route not applied");

    route_open_a: assert property (
        route_w == ROUTE_OPEN |=> !sbu_crossed && !sbu_straight)
        else $error("open route still connects");

    route_pins_a: assert property (
        route_w == ROUTE_PINS && mode_select_high && orientation_select
            |=> sbu_crossed && !sbu_straight)
        else $error("pin driven route wrong");

    host_restore_a: assert property (
        wr_rst && (|rbus.wdata[HOST_RST_LSB +: 4])
            |=> ##1 ctrl_r == CTRL_RST && rst_fld_r == RST_FLD_RST)
        else $error("host restore did not reset and clear");

    link_restore_a: assert property (
        wr_rst && (|rbus.wdata[LINK_RST_LSB +: 4]) ##1 !snoop_lc_wr
            |=> lcount_r == LCOUNT_RST)
        else $error("link restore did not clear lane count");

    strap_follow_a: assert property (
        strap_done_r && !eq_software_takeover
            |=> eq2_r == {strap_code_r, strap_code_r})
        else $error("equalization not following straps");

    sw_eq_a: assert property (
        eq_software_takeover && wr_eq2 && !host_rst
            |=> dfp_tx_pair2_eq_code == $past(rbus.wdata[7:4])
            && dfp_rx_pair2_eq_code == $past(rbus.wdata[3:0]))
        else $error("written equalization code not applied");

    lane_on_a: assert property (
        snoop_off_w && !display_lane0_off |=> display_lane_en[0])
        else $error("manual lane on not applied");

    snoop_all_a: assert property (
        !snoop_off_w && lcount_r == 5'h04 && pstate_r != PSTATE_DOWN
            |=> display_lane_en == 4'hF)
        else $error("four lane count not applied");

    link_pstate_a: assert property (
        wr_rst && (|rbus.wdata[LINK_RST_LSB +: 4]) ##1 !snoop_ps_wr
            |=> pstate_r == PSTATE_RST)
        else $error("link restore did not clear power state");

    host_eq_a: assert property (
        host_rst && eq_software_takeover
            |=> eq1_r == EQ_RST && eq2_r == EQ_RST)
        else $error("host restore did not clear equalization");

    // Strap lock must hold even against a direct register write
    strap_lock_a: assert property (
        strap_done_r && !eq_software_takeover && wr_eq2
            |=> eq2_r == strap_pair_w)
        else $error("write altered strap equalization");

    snoop_mon_a: assert property (
        !snoop_off_w |=> aux_snoop_en)
        else $error("snoop not enabled with bit clear");

    route_straight_a: assert property (
        route_w == ROUTE_STRAIGHT |=> sbu_straight && !sbu_crossed)
        else $error("forced straight route not applied");

    pins_off_a: assert property (
        route_w == ROUTE_PINS && !mode_select_high
            |=> !sbu_straight && !sbu_crossed)
        else $error("route connected with mode select low");

    manual_lane_c: cover property (
        snoop_off_w && lane_off_w == 4'hF ##1 display_lane_en == 4'h0);
    route_cross_c: cover property (route_w == ROUTE_CROSS ##1 sbu_crossed);
    host_restore_c: cover property (host_rst && ctrl_r != CTRL_RST);
    sw_eq_c: cover property (eq_software_takeover && wr_eq2);
endmodule

// [hw/rdr_lane_gate.sv]
// One display lane enable, manual or snoop driven
`timescale 1ns/10ps
module rdr_lane_gate #(
    parameter int LANE = 0
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic snoop_off,
    input wire logic lane_off,
    input wire logic [4:0] lane_count,
    input wire logic [1:0] power_state,
    output logic lane_en
);
    import rdr_pkg::*;
    localparam logic [4:0] LANE_IDX = 5'(LANE);
    logic lane_en_r;
    logic lane_en_nxt;
    logic snoop_en_w;
    // Lanes below the snooped count stay on unless powered down
    assign snoop_en_w = (lane_count > LANE_IDX)
        && (power_state != PSTATE_DOWN);
    // Manual bit only counts with snoop stopped
    assign lane_en_nxt = snoop_off ? ~lane_off : snoop_en_w;
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            lane_en_r <= LANE_EN_RST;
        end else begin
            lane_en_r <= lane_en_nxt;
        end
    end
    assign lane_en = lane_en_r;
endmodule

// [hw/rdr_pkg.sv]
// Constants and types for the redriver lane control registers
package rdr_pkg;
    localparam logic [7:0] ADDR_CTRL = 8'h13;
    localparam logic [7:0] ADDR_RST = 8'h1B;
    localparam logic [7:0] ADDR_EQ2 = 8'h20;
    localparam logic [7:0] ADDR_EQ1 = 8'h21;
    localparam int SNOOP_OFF_BIT = 7;
    localparam int ROUTE_LSB = 4;
    localparam int LANE_LSB = 0;
    localparam int HOST_RST_LSB = 4;
    localparam int LINK_RST_LSB = 0;
    localparam int TX_LSB = 4;
    localparam int RX_LSB = 0;
    localparam logic [7:0] CTRL_RST = 8'h00;
    // Bit 6 is reserved and reads zero
    localparam logic [7:0] CTRL_MASK = 8'hBF;
    localparam logic [7:0] RST_FLD_RST = 8'h00;
    localparam logic [7:0] EQ_RST = 8'h00;
    localparam logic [7:0] RDATA_NONE = 8'h00;
    localparam logic [4:0] LCOUNT_RST = 5'h00;
    localparam logic [1:0] PSTATE_RST = 2'h0;
    localparam logic [1:0] PSTATE_DOWN = 2'h2;
    localparam logic LANE_EN_RST = 1'b0;
    // Bus address value is arbitrary
    localparam logic [6:0] I2C_DEV_ADDR = 7'h2A;
    // Strap pair to code: 00->0, 01->4, 10->8, 11->B
    localparam logic [15:0] STRAP_EQ_MAP = 16'hB840;
    localparam logic [3:0] BIT_CNT_BYTE = 4'h8;
    localparam logic [3:0] BIT_CNT_LAST = 4'h7;
    typedef enum logic [1:0] {
        ROUTE_PINS = 2'h0,
        ROUTE_STRAIGHT = 2'h1,
        ROUTE_CROSS = 2'h2,
        ROUTE_OPEN = 2'h3
    } rdr_route_t;
    typedef enum logic [4:0] {
        I2C_IDLE = 5'h01,
        I2C_RECV = 5'h02,
        I2C_ACK = 5'h04,
        I2C_SEND = 5'h08,
        I2C_MACK = 5'h10
    } rdr_i2c_state_t;
    typedef enum logic [2:0] {
        PH_ADDR = 3'h1,
        PH_PTR = 3'h2,
        PH_DATA = 3'h4
    } rdr_phase_t;
endpackage

// [hw/rdr_rbus_if.sv]
// Byte register access carrier between serial front end and registers
`timescale 1ns/10ps
interface rdr_rbus_if;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic wr;
    modport ctrl (output addr, output wdata, output wr, input rdata);
    modport regs (input addr, input wdata, input wr, output rdata);
endinterface

// [tb/rdr_i2c_host.sv]
// Serial management host model driving the register bus pins
`timescale 1ns/10ps
module rdr_i2c_host (
    input wire logic clk_sys,
    input wire logic sda,
    output logic scl,
    output logic sda_low
);
    import rdr_pkg::*;
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    // Data moves a cycle after the clock falls, never with it
    task automatic put_bit(input logic b, output logic seen);
        tick(1);
        sda_low <= ~b;
        tick(3);
        scl <= 1'b1;
        tick(3);
        seen = sda;
        tick(1);
        scl <= 1'b0;
    endtask
    task automatic xfer(input logic [7:0] tx, input logic rel,
                        output logic [7:0] rx, output logic ack);
        logic b;
        for (int i = 7; i >= 0; i--) begin
            put_bit(tx[i], b);
            rx[i] = b;
        end
        put_bit(rel, b);
        ack = ~b;
    endtask
    task automatic start();
        tick(1);
        sda_low <= 1'b0;
        tick(3);
        scl <= 1'b1;
        tick(4);
        sda_low <= 1'b1;
        tick(4);
        scl <= 1'b0;
    endtask
    task automatic stop();
        tick(1);
        sda_low <= 1'b1;
        tick(3);
        scl <= 1'b1;
        tick(4);
        sda_low <= 1'b0;
        tick(4);
    endtask
    // Host writes any register, eq fields included
    task automatic wr_reg(input logic [6:0] dev, input logic [7:0] addr,
                          input logic [7:0] data, output logic ok);
        logic [7:0] rx;
        logic a0, a1, a2;
        start();
        xfer({dev, 1'b0}, 1'b1, rx, a0);
        xfer(addr, 1'b1, rx, a1);
        xfer(data, 1'b1, rx, a2);
        stop();
        ok = a0 & a1 & a2;
    endtask
    // Pointer write, repeated start, one byte, then no-acknowledge
    task automatic rd_reg(input logic [7:0] addr, output logic [7:0] data,
                          output logic ok);
        logic [7:0] rx;
        logic a0, a1, a2, m;
        start();
        xfer({I2C_DEV_ADDR, 1'b0}, 1'b1, rx, a0);
        xfer(addr, 1'b1, rx, a1);
        start();
        xfer({I2C_DEV_ADDR, 1'b1}, 1'b1, rx, a2);
        xfer(8'hFF, 1'b1, data, m);
        stop();
        ok = a0 & a1 & a2;
    endtask
endmodule

// [tb/redriver_lane_ctrl_regs_tb.sv]
// Self-checking bench for the lane control register block
`timescale 1ns/10ps
module redriver_lane_ctrl_regs_tb;
    import rdr_pkg::*;
    logic clk_sys, resetn, scl, sda_low, sda, sda_out, sda_oe;
    logic eq_software_takeover, mode_select_high, orientation_select;
    logic [1:0] downstream_eq_straps;
    logic snoop_lc_wr, snoop_ps_wr, aux_snoop_en, sbu_straight, sbu_crossed;
    logic [7:0] snoop_data;
    logic [3:0] display_lane_en, tx2, rx2, tx1, rx1;
    int error_cnt = 0;
    int num_checks = 0;
    // Open-drain line with pull-up
    assign sda = (sda_oe ? sda_out : 1'b1) & ~sda_low;
    rdr_lane_ctrl DUT (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .scl(scl),
        .sda_in(sda),
        .sda_out(sda_out),
        .sda_oe(sda_oe),
        .eq_software_takeover(eq_software_takeover),
        .downstream_eq_straps(downstream_eq_straps),
        .mode_select_high(mode_select_high),
        .orientation_select(orientation_select),
        .snoop_lc_wr(snoop_lc_wr),
        .snoop_ps_wr(snoop_ps_wr),
        .snoop_data(snoop_data),
        .aux_snoop_en(aux_snoop_en),
        .sbu_straight(sbu_straight),
        .sbu_crossed(sbu_crossed),
        .display_lane_en(display_lane_en),
        .dfp_tx_pair2_eq_code(tx2),
        .dfp_rx_pair2_eq_code(rx2),
        .dfp_tx_pair1_eq_code(tx1),
        .dfp_rx_pair1_eq_code(rx1)
    );
    rdr_i2c_host host (
        .clk_sys(clk_sys),
        .sda(sda),
        .scl(scl),
        .sda_low(sda_low)
    );
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    task automatic test_done();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic compare(input string nm, input logic [7:0] exp,
                           input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch %s exp %h got %h", nm, exp, got);
        end
    endtask
    task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
        logic [7:0] d;
        logic ok;
        host.rd_reg(addr, d, ok);
        compare("rd_ack", 8'h01, {7'h0, ok});
        compare("rdata", exp, d);
    endtask
    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        logic ok;
        host.wr_reg(I2C_DEV_ADDR, addr, data, ok);
        compare("wr_ack", 8'h01, {7'h0, ok});
        repeat (3) @(posedge clk_sys);
    endtask
    task automatic snoop(input logic lc, input logic [7:0] d);
        @(posedge clk_sys);
        snoop_lc_wr <= lc;
        snoop_ps_wr <= ~lc;
        snoop_data <= d;
        @(posedge clk_sys);
        snoop_lc_wr <= 1'b0;
        snoop_ps_wr <= 1'b0;
        repeat (3) @(posedge clk_sys);
    endtask
    // Watchdog so a stuck bus cannot hang the run
    initial begin
        repeat (100000) @(posedge clk_sys);
        error_cnt++;
        test_done();
    end
    initial begin
        logic [1:0] sbu_exp;
        logic ok;
        resetn = 1'b0;
        eq_software_takeover = 1'b0;
        downstream_eq_straps = 2'b10;
        mode_select_high = 1'b0;
        orientation_select = 1'b0;
        snoop_lc_wr = 1'b0;
        snoop_ps_wr = 1'b0;
        snoop_data = 8'h00;
        repeat (16) @(posedge clk_sys);
        resetn <= 1'b1;
        repeat (4) @(posedge clk_sys);
        compare("snoop_en", 8'h01, {7'h0, aux_snoop_en});
        compare("lanes", 8'h00, {4'h0, display_lane_en});
        compare("tx2", 8'h08, {4'h0, tx2});
        compare("rx1", 8'h08, {4'h0, rx1});
        rd_chk(ADDR_CTRL, CTRL_RST);
        rd_chk(ADDR_EQ2, 8'h88);
        wr(ADDR_EQ2, 8'h5A);
        rd_chk(ADDR_EQ2, 8'h88);
        compare("rx2", 8'h08, {4'h0, rx2});
        snoop(1'b1, 8'h02);
        compare("lanes", 8'h03, {4'h0, display_lane_en});
        snoop(1'b0, {6'h0, PSTATE_DOWN});
        compare("lanes", 8'h00, {4'h0, display_lane_en});
        snoop(1'b0, 8'h00);
        wr(ADDR_CTRL, 8'h05);
        compare("lanes", 8'h03, {4'h0, display_lane_en});
        wr(ADDR_CTRL, 8'hC5);
        compare("snoop_en", 8'h00, {7'h0, aux_snoop_en});
        compare("lanes", 8'h0A, {4'h0, display_lane_en});
        rd_chk(ADDR_CTRL, 8'h85);
        for (int r = 0; r < 4; r++) begin
            wr(ADDR_CTRL, {2'b10, r[1:0], 4'h0});
            for (int k = 0; k < 4; k++) begin
                @(posedge clk_sys);
                mode_select_high <= k[1];
                orientation_select <= k[0];
                repeat (3) @(posedge clk_sys);
                sbu_exp = (r == 0) ? {k[1] & k[0], k[1] & ~k[0]} :
                          (r == 3) ? 2'b00 : r[1:0];
                compare("sbu", {6'h0, sbu_exp},
                        {6'h0, sbu_crossed, sbu_straight});
            end
        end
        @(posedge clk_sys);
        eq_software_takeover <= 1'b1;
        wr(ADDR_EQ2, 8'h5A);
        compare("tx2", 8'h05, {4'h0, tx2});
        compare("rx2", 8'h0A, {4'h0, rx2});
        wr(ADDR_EQ1, 8'h3C);
        compare("tx1", 8'h03, {4'h0, tx1});
        compare("rx1", 8'h0C, {4'h0, rx1});
        rd_chk(ADDR_EQ2, 8'h5A);
        wr(ADDR_CTRL, 8'h30);
        snoop(1'b1, 8'h02);
        compare("lanes", 8'h03, {4'h0, display_lane_en});
        wr(ADDR_RST, 8'h01);
        compare("lanes", 8'h00, {4'h0, display_lane_en});
        rd_chk(ADDR_RST, RST_FLD_RST);
        rd_chk(ADDR_CTRL, 8'h30);
        snoop(1'b1, 8'h04);
        compare("lanes", 8'h0F, {4'h0, display_lane_en});
        wr(ADDR_RST, 8'h10);
        rd_chk(ADDR_RST, RST_FLD_RST);
        rd_chk(ADDR_CTRL, CTRL_RST);
        rd_chk(ADDR_EQ2, EQ_RST);
        compare("lanes", 8'h00, {4'h0, display_lane_en});
        compare("tx1", 8'h00, {4'h0, tx1});
        rd_chk(8'h30, RDATA_NONE);
        // Foreign bus address must be ignored entirely
        host.wr_reg(7'h15, ADDR_CTRL, 8'h80, ok);
        compare("bad_ack", 8'h00, {7'h0, ok});
        compare("snoop_en", 8'h01, {7'h0, aux_snoop_en});
        resetn <= 1'b0;
        eq_software_takeover <= 1'b0;
        downstream_eq_straps <= 2'b11;
        repeat (16) @(posedge clk_sys);
        resetn <= 1'b1;
        repeat (4) @(posedge clk_sys);
        compare("tx1", 8'h0B, {4'h0, tx1});
        rd_chk(ADDR_EQ2, 8'hBB);
        test_done();
    end
endmodule
